/* rtl/pld_defs.vh */
`ifndef PLD_DEFS_VH
`define PLD_DEFS_VH

// ****************************************************************
// Register map
// ****************************************************************
`define PLD_ADDR_LOCK_CTRL   6'h07
`define PLD_ADDR_STATUS      6'h12
`define PLD_CTRL_RESET       24'h00_014d

// ****************************************************************
// Field positions
// ****************************************************************
`define PLD_RUN_CODE_MSB     2
`define PLD_RUN_CODE_LSB     0
`define PLD_ENABLE_BIT       3
`define PLD_WIN_TYPE_BIT     6
`define PLD_WIN_DIV_MSB      9
`define PLD_WIN_DIV_LSB      7
`define PLD_SPEED_MSB        11
`define PLD_SPEED_LSB        10
`define PLD_STATUS_LOCK_BIT  1

// ****************************************************************
// Run lengths for each run code
// ****************************************************************
`define PLD_RUN_0            17'h0_0005
`define PLD_RUN_1            17'h0_0020
`define PLD_RUN_2            17'h0_0060
`define PLD_RUN_3            17'h0_0100
`define PLD_RUN_4            17'h0_0200
`define PLD_RUN_5            17'h0_0800
`define PLD_RUN_6            17'h0_2000
`define PLD_RUN_7            17'h0_ffff

// ****************************************************************
// Timing
// ****************************************************************
`define PLD_CLK_PERIOD_NS    8
`define PLD_ANALOG_WIN_NS    10
`define PLD_ANALOG_WIN_CYC   ((`PLD_ANALOG_WIN_NS) / (`PLD_CLK_PERIOD_NS))

`endif

/* rtl/pld_edge_sync.v */
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Three-stage synchroniser with rising-edge pulse
// ****************************************************************
module pld_edge_sync (
    // Clock and reset
    input  wire CLK_IN,
    input  wire RESET_IN,
    // Asynchronous edge source
    input  wire ASYNC_IN,
    // One-cycle pulse on a settled rising edge
    output wire RISE_OUT
);

    reg [2:0] sync_reg;
    reg       stable_reg;

    // The value only counts once stages two and three agree; stage one
    // feeds nothing but stage two so metastability cannot leak.
    always @(posedge CLK_IN) begin
        if (RESET_IN) begin
            sync_reg   <= 3'h0;
            stable_reg <= 1'b0;
        end else begin
            sync_reg <= {sync_reg[1:0], ASYNC_IN};
            if (sync_reg[1] == sync_reg[2]) begin
                stable_reg <= sync_reg[2];
            end
        end
    end

    assign RISE_OUT = (sync_reg[1] == sync_reg[2]) && sync_reg[2] && !stable_reg;

endmodule

`default_nettype wire

/* rtl/pld_lock_detector.v */
`include "pld_defs.vh"
`timescale 1ns/1ns
`default_nettype none

module pld_lock_detector (
    // Clock and reset
    input  wire        CLK_IN,
    input  wire        RESET_IN,
    // Phase comparator edges from pins
    input  wire        REF_EDGE_IN,
    input  wire        DIV_OSC_EDGE_IN,
    // Register access from the serial port
    input  wire        REG_WR_IN,
    input  wire [5:0]  REG_ADDR_IN,
    input  wire [23:0] REG_WDATA_IN,
    output reg  [23:0] REG_RDATA_OUT,
    // Shared pin control from the serial port
    input  wire [4:0]  OUTPUT_SELECT_IN,
    input  wire        PIN_SHARE_IN,
    input  wire        SERIAL_READ_ACTIVE_IN,
    input  wire        SERIAL_READ_DATA_IN,
    // Lock indication
    output reg         LOCK_INDICATION_OUT,
    output reg         LOCK_OR_SERIAL_OUT_PIN_OUT
);

    // ****************************************************************
    // Measurement states
    // ****************************************************************
    localparam ST_IDLE     = 2'b00;
    localparam ST_WAIT_OSC = 2'b01;
    localparam ST_WAIT_REF = 2'b10;
    localparam ST_WAIT_END = 2'b11;

    reg  [23:0] ctrl_reg;
    reg  [1:0]  state_reg;
    reg  [12:0] gap_reg;
    reg  [16:0] run_reg;
    reg         lock_reg;
    wire        ref_rise;
    wire        osc_rise;

    // Run length decode for the run code.
    function [16:0] run_target;
        input [2:0] code;
        begin
            case (code)
                3'h0: run_target = `PLD_RUN_0;
                3'h1: run_target = `PLD_RUN_1;
                3'h2: run_target = `PLD_RUN_2;
                3'h3: run_target = `PLD_RUN_3;
                3'h4: run_target = `PLD_RUN_4;
                3'h5: run_target = `PLD_RUN_5;
                3'h6: run_target = `PLD_RUN_6;
                default: run_target = `PLD_RUN_7;
            endcase
        end
    endfunction

    // Window length in half system clock cycles. The internal timer tick
    // is modelled as speed+1 system clocks, so slower codes stretch it.
    function [12:0] win_halves;
        input [1:0] speed;
        input [2:0] div;
        begin
            win_halves = ({11'h000, speed} + 13'h0001) << div;
        end
    endfunction

    // ****************************************************************
    // Edge synchronisers
    // ****************************************************************
    pld_edge_sync u_ref_sync (
        .CLK_IN   (CLK_IN),
        .RESET_IN (RESET_IN),
        .ASYNC_IN (REF_EDGE_IN),
        .RISE_OUT (ref_rise)
    );

    pld_edge_sync u_osc_sync (
        .CLK_IN   (CLK_IN),
        .RESET_IN (RESET_IN),
        .ASYNC_IN (DIV_OSC_EDGE_IN),
        .RISE_OUT (osc_rise)
    );

    // ****************************************************************
    // Window selection
    // ****************************************************************
    wire        enable   = ctrl_reg[`PLD_ENABLE_BIT];
    wire [1:0]  speed    = ctrl_reg[`PLD_SPEED_MSB:`PLD_SPEED_LSB];
    wire [2:0]  win_div  = ctrl_reg[`PLD_WIN_DIV_MSB:`PLD_WIN_DIV_LSB];
    // The analog window is reckoned as whole system clocks, held as halves.
    localparam [31:0] ANALOG_HALVES = `PLD_ANALOG_WIN_CYC * 2;
    wire [12:0] analog_h = ANALOG_HALVES[12:0];
    wire [12:0] digit_h  = win_halves(speed, win_div);
    reg  [12:0] limit_h;

    always @* begin
        if (ctrl_reg[`PLD_WIN_TYPE_BIT]) begin
            limit_h = digit_h;
        end else begin
            limit_h = analog_h;
        end
    end

    // The counter is cleared on the lead edge's cycle, so the gap seen now is
    // the count plus one; a gap is in window while twice it stays below it.
    wire        next_out = ({gap_reg + 13'h0001, 1'b0}) >= {1'b0, limit_h};
    wire        in_win   = !next_out;
    wire        both     = ref_rise && osc_rise;

    // ****************************************************************
    // Comparison and run counting
    // ****************************************************************
    reg         cmp_done;
    reg         cmp_pass;

    always @* begin
        cmp_done = 1'b0;
        cmp_pass = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (both) begin
                    cmp_done = 1'b1;
                    cmp_pass = 1'b1;
                end
            end
            ST_WAIT_OSC: begin
                if (osc_rise) begin
                    cmp_done = 1'b1;
                    cmp_pass = in_win;
                end else if (next_out) begin
                    cmp_done = 1'b1;
                end
            end
            ST_WAIT_REF: begin
                if (ref_rise) begin
                    cmp_done = 1'b1;
                    cmp_pass = in_win;
                end else if (next_out) begin
                    cmp_done = 1'b1;
                end
            end
            default: begin
                cmp_done = 1'b0;
            end
        endcase
    end

    // Whichever edge leads opens the measurement; a gap that outgrows the
    // window fails early and then waits for the late edge so it is not
    // mistaken for the lead of the next comparison.
    always @(posedge CLK_IN) begin
        if (RESET_IN || !enable) begin
            state_reg <= ST_IDLE;
            gap_reg   <= 13'h0000;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    gap_reg <= 13'h0000;
                    if (!both && ref_rise) begin
                        state_reg <= ST_WAIT_OSC;
                    end else if (!both && osc_rise) begin
                        state_reg <= ST_WAIT_REF;
                    end
                end
                ST_WAIT_OSC: begin
                    gap_reg <= gap_reg + 13'h0001;
                    if (osc_rise) begin
                        state_reg <= ST_IDLE;
                    end else if (next_out) begin
                        state_reg <= ST_WAIT_END;
                    end
                end
                ST_WAIT_REF: begin
                    gap_reg <= gap_reg + 13'h0001;
                    if (ref_rise) begin
                        state_reg <= ST_IDLE;
                    end else if (next_out) begin
                        state_reg <= ST_WAIT_END;
                    end
                end
                default: begin
                    if (ref_rise || osc_rise) begin
                        state_reg <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    always @(posedge CLK_IN) begin
        if (RESET_IN || !enable) begin
            run_reg  <= 17'h0_0000;
            lock_reg <= 1'b0;
        end else if (cmp_done && !cmp_pass) begin
            run_reg  <= 17'h0_0000;
            lock_reg <= 1'b0;
        end else if (cmp_done) begin
            if (run_reg + 17'h0_0001 >= run_target(ctrl_reg[`PLD_RUN_CODE_MSB:`PLD_RUN_CODE_LSB])) begin
                lock_reg <= 1'b1;
            end else begin
                run_reg <= run_reg + 17'h0_0001;
            end
        end
    end

    // ****************************************************************
    // Registers and outputs
    // ****************************************************************
    // Control register write; the status register is read-only.
    always @(posedge CLK_IN) begin
        if (RESET_IN) begin
            ctrl_reg <= `PLD_CTRL_RESET;
        end else if (REG_WR_IN && REG_ADDR_IN == `PLD_ADDR_LOCK_CTRL) begin
            ctrl_reg <= REG_WDATA_IN;
        end
    end

    always @(posedge CLK_IN) begin
        if (RESET_IN) begin
            REG_RDATA_OUT              <= 24'h00_0000;
            LOCK_INDICATION_OUT        <= 1'b0;
            LOCK_OR_SERIAL_OUT_PIN_OUT <= 1'b0;
        end else begin
            LOCK_INDICATION_OUT <= lock_reg;
            if (REG_ADDR_IN == `PLD_ADDR_LOCK_CTRL) begin
                REG_RDATA_OUT <= ctrl_reg;
            end else if (REG_ADDR_IN == `PLD_ADDR_STATUS) begin
                REG_RDATA_OUT <= {22'h00_0000, lock_reg, 1'b0};
            end else begin
                REG_RDATA_OUT <= 24'h00_0000;
            end
            if (SERIAL_READ_ACTIVE_IN) begin
                LOCK_OR_SERIAL_OUT_PIN_OUT <= SERIAL_READ_DATA_IN;
            end else if (OUTPUT_SELECT_IN == 5'h01 || !PIN_SHARE_IN) begin
                LOCK_OR_SERIAL_OUT_PIN_OUT <= lock_reg;
            end else begin
                LOCK_OR_SERIAL_OUT_PIN_OUT <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

/* verification/pld_lock_detector_sva.sv */
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Port checker for the lock detector
// ****************************************
module pld_lock_detector_sva (
    input wire logic        CLK_IN,
    input wire logic        RESET_IN,
    input wire logic        REG_WR_IN,
    input wire logic [5:0]  REG_ADDR_IN,
    input wire logic [23:0] REG_WDATA_IN,
    input wire logic [23:0] REG_RDATA_OUT,
    input wire logic [4:0]  OUTPUT_SELECT_IN,
    input wire logic        PIN_SHARE_IN,
    input wire logic        SERIAL_READ_ACTIVE_IN,
    input wire logic        SERIAL_READ_DATA_IN,
    input wire logic        LOCK_INDICATION_OUT,
    input wire logic        LOCK_OR_SERIAL_OUT_PIN_OUT
);
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (RESET_IN);
    // Reset must clear every output, so this one is not disabled by reset.
    reset_clear_a: assert property (disable iff (1'b0) RESET_IN |=>
        !LOCK_INDICATION_OUT && !LOCK_OR_SERIAL_OUT_PIN_OUT && REG_RDATA_OUT == 24'h00_0000)
        else $error("outputs not cleared by reset");
    // Status word carries only the lock bit.
    status_bits_a: assert property (!$past(RESET_IN) && $past(REG_ADDR_IN) == 6'h12 |->
        REG_RDATA_OUT[23:2] == 22'h00_0000 && !REG_RDATA_OUT[0]) else $error("status spare bits set");
    unmapped_zero_a: assert property (!$past(RESET_IN) && $past(REG_ADDR_IN) != 6'h07 &&
        $past(REG_ADDR_IN) != 6'h12 |-> REG_RDATA_OUT == 24'h00_0000) else $error("unmapped read not zero");
    // A write is seen on readback two edges later.
    write_back_a: assert property (REG_WR_IN && REG_ADDR_IN == 6'h07 ##1 !REG_WR_IN &&
        REG_ADDR_IN == 6'h07 |=> REG_RDATA_OUT == $past(REG_WDATA_IN, 2)) else $error("control readback wrong");
    ctrl_hold_a: assert property (!$past(RESET_IN) && $past(REG_ADDR_IN) == 6'h07 && !$past(REG_WR_IN) &&
        REG_ADDR_IN == 6'h07 |=> $stable(REG_RDATA_OUT)) else $error("control changed without write");
    enable_off_a: assert property (REG_WR_IN && REG_ADDR_IN == 6'h07 && !REG_WDATA_IN[3] |->
        ##3 !LOCK_INDICATION_OUT) else $error("lock kept while disabled");
    serial_pin_a: assert property (!$past(RESET_IN) && $past(SERIAL_READ_ACTIVE_IN) |->
        LOCK_OR_SERIAL_OUT_PIN_OUT == $past(SERIAL_READ_DATA_IN)) else $error("pin not carrying read data");
    lock_pin_a: assert property (!$past(RESET_IN) && !$past(SERIAL_READ_ACTIVE_IN) &&
        ($past(OUTPUT_SELECT_IN) == 5'h01 || !$past(PIN_SHARE_IN)) && $stable(LOCK_INDICATION_OUT) |->
        LOCK_OR_SERIAL_OUT_PIN_OUT == LOCK_INDICATION_OUT) else $error("pin does not follow lock");
    idle_pin_a: assert property (!$past(RESET_IN) && !$past(SERIAL_READ_ACTIVE_IN) &&
        $past(OUTPUT_SELECT_IN) != 5'h01 && $past(PIN_SHARE_IN) |-> !LOCK_OR_SERIAL_OUT_PIN_OUT)
        else $error("pin driven while unselected");
    lock_rise_c: cover property ($rose(LOCK_INDICATION_OUT));
    lock_fall_c: cover property ($fell(LOCK_INDICATION_OUT));
    serial_read_c: cover property (SERIAL_READ_ACTIVE_IN && LOCK_INDICATION_OUT);
endmodule
`default_nettype wire

/* verification/pld_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Host controller on the register port
// ****************************************
module pld_host_model (
    input  wire logic        clk_in,
    input  wire logic [23:0] rdata_in,
    output var  logic        wr_out,
    output var  logic [5:0]  addr_out,
    output var  logic [23:0] wdata_out
);
    // Idle port at time zero.
    initial begin
        wr_out = 1'b0;
        addr_out = 6'h00;
        wdata_out = 24'h00_0000;
    end
    // One write; data is scrambled afterwards so a late sample cannot pass by luck.
    task automatic wr(input logic [5:0] a, input logic [23:0] d);
        @(negedge clk_in);
        addr_out = a;
        wdata_out = d;
        wr_out = 1'b1;
        @(negedge clk_in);
        wr_out = 1'b0;
        wdata_out = ~d;
    endtask
    // Read data is registered from the address, so it is taken one edge later.
    task automatic rd(input logic [5:0] a, output logic [23:0] d);
        @(negedge clk_in);
        addr_out = a;
        @(negedge clk_in);
        d = rdata_in;
    endtask
    function automatic logic [23:0] ctrl(input logic [2:0] run, input logic dig, input logic [2:0] dv,
                                         input logic [1:0] sp);
        ctrl = {12'h000, sp, dv, dig, 2'b00, 1'b1, run};
    endfunction
endmodule
`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Lock detector bench
// ****************************************
module tb_top;
    logic        clk;
    logic        rst;
    logic        ref_e;
    logic        div_e;
    logic [4:0]  sel;
    logic        share;
    logic        rd_act;
    logic        rd_dat;
    logic        wr;
    logic [5:0]  addr;
    logic [23:0] wdata;
    logic [23:0] rdata;
    logic [23:0] got;
    logic        lock;
    logic        pin;
    int          error_cnt;
    int          num_checks;
    pld_host_model host_u (.clk_in(clk), .rdata_in(rdata), .wr_out(wr), .addr_out(addr), .wdata_out(wdata));
    pld_lock_detector dut_u (.CLK_IN(clk), .RESET_IN(rst), .REF_EDGE_IN(ref_e), .DIV_OSC_EDGE_IN(div_e),
        .REG_WR_IN(wr), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata),
        .OUTPUT_SELECT_IN(sel), .PIN_SHARE_IN(share), .SERIAL_READ_ACTIVE_IN(rd_act),
        .SERIAL_READ_DATA_IN(rd_dat), .LOCK_INDICATION_OUT(lock), .LOCK_OR_SERIAL_OUT_PIN_OUT(pin));
    // System clock, 8 ns period.
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic flag(input logic seen, input logic exp);
        check({23'h0, seen}, {23'h0, exp});
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Edge pair with the given lead in cycles; pins held long enough to pass the synchroniser.
    task automatic pair(input int gap, input logic ref_first);
        @(negedge clk);
        ref_e = ref_first || gap == 0;
        div_e = !ref_first || gap == 0;
        if (gap > 0) begin
            repeat (gap) @(negedge clk);
            ref_e = 1'b1;
            div_e = 1'b1;
        end
        repeat (5) @(negedge clk);
        ref_e = 1'b0;
        div_e = 1'b0;
        repeat (5) @(negedge clk);
    endtask
    task automatic t_regs;
        host_u.rd(6'h07, got);
        check(got, 24'h00_014d);
        host_u.wr(6'h12, 24'hff_ffff);
        host_u.rd(6'h12, got);
        check(got, 24'h00_0000);
        host_u.rd(6'h3f, got);
        check(got, 24'h00_0000);
        for (int i = 0; i < 8; i++) begin
            host_u.wr(6'h07, host_u.ctrl(i[2:0], 1'b1, i[2:0], i[1:0]));
            host_u.rd(6'h07, got);
            check(got, 24'h00_0048 | (i[2:0] << 7) | (i[1:0] << 10) | i[2:0]);
        end
        $display("done regs");
    endtask
    // Disabling first clears the run, so the count starts from zero.
    task automatic t_run(input logic [2:0] code, input int n);
        host_u.wr(6'h07, 24'h00_0000);
        host_u.wr(6'h07, host_u.ctrl(code, 1'b1, 3'h2, 2'h0));
        repeat (n - 1) pair(0, 1'b0);
        flag(lock, 1'b0);
        pair(0, 1'b0);
        flag(lock, 1'b1);
        host_u.rd(6'h12, got);
        check(got, 24'h00_0002);
        $display("done run %0d", n);
    endtask
    // Default window is four half ticks: a lead of one passes, two fails.
    task automatic t_window;
        pair(1, 1'b1);
        pair(1, 1'b0);
        flag(lock, 1'b1);
        pair(2, 1'b0);
        flag(lock, 1'b0);
        repeat (4) pair(1, 1'b1);
        flag(lock, 1'b0);
        pair(0, 1'b1);
        flag(lock, 1'b1);
        host_u.wr(6'h07, host_u.ctrl(3'h0, 1'b1, 3'h2, 2'h1));
        pair(3, 1'b1);
        flag(lock, 1'b1);
        host_u.wr(6'h07, host_u.ctrl(3'h0, 1'b0, 3'h2, 2'h1));
        pair(1, 1'b0);
        flag(lock, 1'b0);
        repeat (5) pair(0, 1'b1);
        flag(lock, 1'b1);
        $display("done window");
    endtask
    task automatic t_pin;
        sel = 5'h01;
        repeat (2) @(negedge clk);
        flag(pin, 1'b1);
        sel = 5'h00;
        repeat (2) @(negedge clk);
        flag(pin, 1'b0);
        share = 1'b0;
        rd_act = 1'b1;
        repeat (2) @(negedge clk);
        flag(pin, 1'b0);
        rd_act = 1'b0;
        repeat (2) @(negedge clk);
        flag(pin, 1'b1);
        share = 1'b1;
        rd_act = 1'b1;
        rd_dat = 1'b1;
        repeat (2) @(negedge clk);
        flag(pin, 1'b1);
        share = 1'b0;
        rd_act = 1'b0;
        rd_dat = 1'b0;
        host_u.wr(6'h07, 24'h00_0140);
        repeat (5) pair(0, 1'b1);
        flag(lock, 1'b0);
        flag(pin, 1'b0);
        $display("done pin");
    endtask
    // Main sequence: reset for 12 cycles, then the scenarios.
    initial begin
        rst = 1'b1;
        ref_e = 1'b0;
        div_e = 1'b0;
        sel = 5'h00;
        share = 1'b1;
        rd_act = 1'b0;
        rd_dat = 1'b0;
        error_cnt = 0;
        num_checks = 0;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        t_regs;
        t_run(3'h1, 32);
        t_run(3'h0, 5);
        t_window;
        t_pin;
        complete_run;
    end
    // The scenarios need well under 5000 cycles.
    initial begin
        #200000;
        error_cnt++;
        complete_run;
    end
endmodule
bind pld_lock_detector pld_lock_detector_sva chk_u (.CLK_IN(CLK_IN), .RESET_IN(RESET_IN),
    .REG_WR_IN(REG_WR_IN), .REG_ADDR_IN(REG_ADDR_IN), .REG_WDATA_IN(REG_WDATA_IN),
    .REG_RDATA_OUT(REG_RDATA_OUT), .OUTPUT_SELECT_IN(OUTPUT_SELECT_IN), .PIN_SHARE_IN(PIN_SHARE_IN),
    .SERIAL_READ_ACTIVE_IN(SERIAL_READ_ACTIVE_IN), .SERIAL_READ_DATA_IN(SERIAL_READ_DATA_IN),
    .LOCK_INDICATION_OUT(LOCK_INDICATION_OUT), .LOCK_OR_SERIAL_OUT_PIN_OUT(LOCK_OR_SERIAL_OUT_PIN_OUT));
`default_nettype wire
